// [hdl/sld_regs.svh]
// Purpose: Constants for the segment display waveform driver
// Assumes: Included by bare name
// Notes:   Offsets are display memory byte offsets
`ifndef SLD_REGS_SVH
`define SLD_REGS_SVH
`define SLD_RAM_FIRST      8'h08
`define SLD_RAM_LAST       8'h1B
`define SLD_NUM_FP         40
`define SLD_NUM_BP         4
`define SLD_DIV_BASE       32'h0000_0400
`define SLD_DUTY_RESET     2'h0
`define SLD_PRESCALE_RESET 3'h0
`define SLD_LVL_GND        2'h0
`define SLD_LVL_LOW        2'h1
`define SLD_LVL_HIGH       2'h2
`define SLD_LVL_SUPPLY     2'h3
`endif

// [hdl/sld_pkg.sv]
// Purpose: Types for the segment display waveform driver
// Assumes: None
// Notes:   Duty codes match the duty select pair {hi, lo}
package sld_pkg;
  typedef enum logic [1:0] {
    SLD_DUTY_QUARTER = 2'b00,
    SLD_DUTY_FULL    = 2'b01,
    SLD_DUTY_HALF    = 2'b10,
    SLD_DUTY_THIRD   = 2'b11
  } sld_duty_e;
  typedef enum logic [1:0] {
    SLD_ST_OFF  = 2'b00,
    SLD_ST_RUN  = 2'b01,
    SLD_ST_HALT = 2'b10
  } sld_state_e;
  typedef logic [1:0] sld_level_t;
endpackage

// [hdl/sld_prescaler.sv]
// Purpose: Divides source clock ticks down to the display clock tick
// Assumes: srcTick is a one-cycle enable at the source clock rate
// Notes:   Counter holds while run is low, so a halt resumes mid-period
`timescale 1ns/1ps
module sld_prescaler #(
  parameter int DIV_BASE = 1024
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       srcTick,
  input  wire logic       run,
  input  wire logic       clear,
  input  wire logic [2:0] divSel,
  output logic            lcdTick
);
  localparam int CNT_W = $clog2(DIV_BASE) + 8;

  initial begin
    if (DIV_BASE < 2 || (DIV_BASE & (DIV_BASE - 1)) != 0) begin
      $error("DIV_BASE must be a power of two of at least 2");
    end
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] limit;
  logic             wrap;

  assign limit = CNT_W'(DIV_BASE) << divSel;
  assign wrap  = run && srcTick && (cnt_r == limit - CNT_W'(1));
  assign lcdTick = wrap;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (clear) begin
      cnt_r <= '0;
    end else if (run && srcTick) begin
      // Prescale lowered mid-count: wrap rather than run the long way round
      cnt_r <= (cnt_r >= limit - CNT_W'(1)) ? '0 : cnt_r + CNT_W'(1);
    end
  end

  // A tick must restart the count, so two ticks never fall back to back
  property p_tick_restart;
    @(posedge clk_sys) disable iff (!rst_b)
    lcdTick |=> (cnt_r == '0) && !lcdTick;
  endproperty
  a_tick_restart: assert property (p_tick_restart)
    else $error("Display tick did not restart the divider count");
endmodule // sld_prescaler

// [hdl/sld_driver.sv]
// Purpose: Multiplexed segment display backplane and frontplane sequencer
// Assumes: Control inputs synchronous to clk_sys; ircTick is the RC source enable
// Notes:   Pin outputs are enable plus a two-bit bias level index per pin
//
// Contract
// - Reset gives quarter duty, four backplanes, one-third bias.
// - Reset clears frontplane enables and display on; all pins undriven.
// - Display clock is source divided by 1024 shifted left by prescale.
// - A frame lasts one display clock per active backplane.
// - Segment memory holds 160 bits, one per segment.
// - Bit one drives segment on only with display on and enable set.
// - Segment memory readable any time; plain storage while display off.
// - Display on bit accesses never change segment memory.
// - Enabled frontplane waits for display on, starts at once if on.
// - Exactly five duty and bias combinations exist.
// - Backplane waveforms repeat every two frames, polarity inverted each frame, independent of segment data.
// - Frontplane waveform built from its own segment bits.
// - Duty field 01 one, 10 two, 11 three, 00 four backplanes.
// - Bias select picks half or third bias at half duty only.
// - Backplanes unused by duty stay undriven.
// - Halt in wait stops clocks and grounds enabled pins.
// - Memory and controls survive wait.
// - Stop mode stops clocks, grounds enabled pins, keeps contents.
// - Leaving stop resumes clocks if display on, pins as before.
// - Memory bytes 0x08 to 0x1B; low nibble even frontplane.
`timescale 1ns/1ps
`include "sld_regs.svh"
module sld_driver #(
  parameter int NUM_FP   = `SLD_NUM_FP,
  parameter int DIV_BASE = `SLD_DIV_BASE
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic                  ircTick,
  input  wire logic                  displayOn,
  input  wire logic [NUM_FP-1:0]     frontplaneOutputEnable,
  input  wire logic [2:0]            lcdClockPrescale,
  input  wire logic                  dutySelectHi,
  input  wire logic                  dutySelectLo,
  input  wire logic                  biasSelect,
  input  wire logic                  haltInWait,
  input  wire logic                  waitMode,
  input  wire logic                  stopMode,
  input  wire logic                  ramWrEn,
  input  wire logic                  ramRdEn,
  input  wire logic [7:0]            ramAddr,
  input  wire logic [7:0]            ramWrData,
  output logic [7:0]                 ramRdData,
  output logic [3:0]                 backplaneOutputEnable,
  output logic [7:0]                 backplaneLevel,
  output logic [NUM_FP-1:0]          frontplaneDriveEnable,
  output logic [2*NUM_FP-1:0]        frontplaneLevel,
  output logic                       frameStart,
  output sld_pkg::sld_state_e        driverState
);
  import sld_pkg::*;
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  localparam int NUM_BP = `SLD_NUM_BP;
  localparam int BYTES  = NUM_FP / 2;
  initial begin
    if (NUM_FP < 2 || NUM_FP > `SLD_NUM_FP || (NUM_FP % 2) != 0) begin
      $error("NUM_FP must be even and between 2 and 40");
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control capture

  logic              dispOn_r;
  logic [NUM_FP-1:0] fpEn_r;
  logic [2:0]        prescale_r;
  sld_duty_e         duty_r;
  logic              biasSel_r;
  logic              haltWait_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dispOn_r   <= 1'b0;
      fpEn_r     <= '0;
      prescale_r <= `SLD_PRESCALE_RESET;
      duty_r     <= sld_duty_e'(`SLD_DUTY_RESET);
      biasSel_r  <= 1'b0;
      haltWait_r <= 1'b0;
    end else begin
      // Mirrors keep running in wait and stop; the owner holds the values
      dispOn_r   <= displayOn;
      fpEn_r     <= frontplaneOutputEnable;
      prescale_r <= lcdClockPrescale;
      duty_r     <= sld_duty_e'({dutySelectHi, dutySelectLo});
      biasSel_r  <= biasSelect;
      haltWait_r <= haltInWait;
    end
  end

  // Backplane count from duty
  logic [2:0] numBp;
  logic [1:0] lastPhase;
  logic       biasThird;

  always_comb begin
    unique case (duty_r)
      SLD_DUTY_FULL:    numBp = 3'd1;
      SLD_DUTY_HALF:    numBp = 3'd2;
      SLD_DUTY_THIRD:   numBp = 3'd3;
      SLD_DUTY_QUARTER: numBp = 3'd4;
    endcase
  end
  assign lastPhase = 2'(numBp - 3'd1);
  // Full duty behaves the same under either bias; half duty alone chooses
  assign biasThird = (duty_r == SLD_DUTY_THIRD) || (duty_r == SLD_DUTY_QUARTER) ||
                     ((duty_r == SLD_DUTY_HALF) && biasSel_r);

  ////////////////////////////////////////////////////////////////////////////////
  // Run state

  sld_state_e state_r;
  sld_state_e state_nxt;
  logic       halted;
  assign halted = stopMode || (waitMode && haltWait_r);
  always_comb begin
    unique case (state_r)
      SLD_ST_OFF, SLD_ST_RUN, SLD_ST_HALT: begin
        if (!dispOn_r) begin
          state_nxt = SLD_ST_OFF;
        end else if (halted) begin
          state_nxt = SLD_ST_HALT;
        end else begin
          state_nxt = SLD_ST_RUN;
        end
      end
      default: state_nxt = SLD_ST_OFF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SLD_ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign driverState = state_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Display clock and phase sequencing

  logic       lcdTick;
  logic [1:0] phase_r;
  logic       polarity_r;
  logic       frameStart_r;

  sld_prescaler #(
    .DIV_BASE (DIV_BASE)
  ) u_prescaler (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .srcTick (ircTick),
    .run     (state_r == SLD_ST_RUN),
    .clear   (state_r == SLD_ST_OFF),
    .divSel  (prescale_r),
    .lcdTick (lcdTick)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_r      <= 2'd0;
      polarity_r   <= 1'b0;
      frameStart_r <= 1'b0;
    end else if (state_r == SLD_ST_OFF) begin
      phase_r      <= 2'd0;
      polarity_r   <= 1'b0;
      frameStart_r <= 1'b0;
    end else begin
      frameStart_r <= 1'b0;
      if (lcdTick) begin
        if (phase_r >= lastPhase) begin
          // Polarity flips per frame so no segment sees a DC component
          phase_r      <= 2'd0;
          polarity_r   <= ~polarity_r;
          frameStart_r <= 1'b1;
        end else begin
          phase_r <= phase_r + 2'd1;
        end
      end
    end
  end
  assign frameStart = frameStart_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Segment memory

  logic [7:0]          mem [0:BYTES-1];
  logic [NUM_FP*4-1:0] segBits;
  logic                addrHit;
  logic [4:0]          addrIdx;
  logic [7:0]          rdData_r;

  assign addrIdx = 5'(ramAddr - `SLD_RAM_FIRST);
  assign addrHit = (ramAddr >= `SLD_RAM_FIRST) && (ramAddr <= `SLD_RAM_LAST) &&
                   (int'(addrIdx) < BYTES);

  // No reset: contents are undefined until software fills them
  always_ff @(posedge clk_sys) begin
    if (ramWrEn && addrHit) begin
      mem[addrIdx] <= ramWrData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r <= 8'h00;
    end else if (ramRdEn) begin
      rdData_r <= addrHit ? mem[addrIdx] : 8'h00;
    end
  end
  assign ramRdData = rdData_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive

  logic [3:0]          bpOeNxt;
  logic [7:0]          bpLvlNxt;
  logic [NUM_FP-1:0]   fpOeNxt;
  logic [2*NUM_FP-1:0] fpLvlNxt;
  logic [3:0]          bpOe_r;
  logic [7:0]          bpLvl_r;
  logic [NUM_FP-1:0]   fpOe_r;
  logic [2*NUM_FP-1:0] fpLvl_r;
  logic                grounded;
  assign grounded = (state_r == SLD_ST_HALT);
  genvar g;
  generate
    for (g = 0; g < BYTES; g++) begin : g_seg
      assign segBits[g*8 +: 8] = mem[g];
    end
    for (g = 0; g < NUM_BP; g++) begin : g_bp
      sld_level_t raw;
      assign raw = (phase_r == 2'(g)) ? `SLD_LVL_SUPPLY : `SLD_LVL_LOW;
      assign bpOeNxt[g] = dispOn_r && (g < int'(numBp));
      assign bpLvlNxt[g*2 +: 2] = grounded ? `SLD_LVL_GND : (raw ^ {2{polarity_r}});
    end
    for (g = 0; g < NUM_FP; g++) begin : g_fp
      sld_level_t raw;
      logic       segOn;
      assign segOn = segBits[g*4 + int'(phase_r)];
      assign raw = segOn ? `SLD_LVL_GND :
                   (biasThird ? `SLD_LVL_HIGH : `SLD_LVL_SUPPLY);
      assign fpOeNxt[g] = dispOn_r && fpEn_r[g];
      assign fpLvlNxt[g*2 +: 2] = grounded ? `SLD_LVL_GND : (raw ^ {2{polarity_r}});
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bpOe_r  <= 4'h0;
      bpLvl_r <= 8'h00;
      fpOe_r  <= '0;
      fpLvl_r <= '0;
    end else begin
      bpOe_r  <= bpOeNxt;
      bpLvl_r <= bpLvlNxt;
      fpOe_r  <= fpOeNxt;
      fpLvl_r <= fpLvlNxt;
    end
  end
  assign backplaneOutputEnable = bpOe_r;
  assign backplaneLevel        = bpLvl_r;
  assign frontplaneDriveEnable = fpOe_r;
  assign frontplaneLevel       = fpLvl_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_unused_bp_off;
    (duty_r != SLD_DUTY_QUARTER) |=> !backplaneOutputEnable[3];
  endproperty
  a_unused_bp_off: assert property (p_unused_bp_off)
    else $error("Unused backplane 3 driven");
  property p_full_duty_single;
    (duty_r == SLD_DUTY_FULL) |=> (backplaneOutputEnable[3:1] == 3'h0);
  endproperty
  a_full_duty_single: assert property (p_full_duty_single)
    else $error("Full duty drives more than backplane 0");
  property p_fp_gated;
    frontplaneDriveEnable[0] |-> $past(dispOn_r && fpEn_r[0]);
  endproperty
  a_fp_gated: assert property (p_fp_gated)
    else $error("Frontplane 0 driven without display on and enable");
  property p_off_undriven;
    !dispOn_r |=> (backplaneOutputEnable == 4'h0) && (frontplaneDriveEnable == '0);
  endproperty
  a_off_undriven: assert property (p_off_undriven)
    else $error("Pins driven while display off");
  property p_halt_ground;
    (state_r == SLD_ST_HALT) |=> (backplaneLevel == 8'h00) && (frontplaneLevel == '0);
  endproperty
  a_halt_ground: assert property (p_halt_ground)
    else $error("Halted pins not at driver ground");
  property p_halt_frozen;
    (state_r == SLD_ST_HALT) && $past(state_r == SLD_ST_HALT) |-> $stable(phase_r);
  endproperty
  a_halt_frozen: assert property (p_halt_frozen)
    else $error("Phase advanced while halted");
  property p_frame_wrap;
    (state_r != SLD_ST_OFF) && lcdTick && (phase_r == lastPhase) |=>
      frameStart && (phase_r == 2'd0);
  endproperty
  a_frame_wrap: assert property (p_frame_wrap)
    else $error("Frame did not wrap after the last backplane");
  property p_bp_select;
    (state_r == SLD_ST_RUN) && (phase_r == 2'd0) && !polarity_r |=>
      (backplaneLevel[1:0] == `SLD_LVL_SUPPLY);
  endproperty
  a_bp_select: assert property (p_bp_select)
    else $error("Selected backplane 0 not at supply level");
  property p_seg_on;
    (state_r == SLD_ST_RUN) && segBits[phase_r] && !polarity_r |=>
      (frontplaneLevel[1:0] == `SLD_LVL_GND);
  endproperty
  a_seg_on: assert property (p_seg_on)
    else $error("On segment of frontplane 0 not at ground level");
  property p_mem_hold;
    !ramWrEn |=> $stable(segBits);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("Segment memory changed without a write");
  c_quarter_frame: cover property (frameStart && (duty_r == SLD_DUTY_QUARTER));
  c_full_frame: cover property (frameStart && (duty_r == SLD_DUTY_FULL));
  c_halt_resume: cover property ((state_r == SLD_ST_HALT) ##1 (state_r == SLD_ST_RUN));
  c_mem_write: cover property (ramWrEn && addrHit && dispOn_r);
endmodule // sld_driver

// [tb/sld_glass.sv]
// Purpose: Passive segment glass model, reports which segments lit in each frame
// Assumes: Level index 0..3 runs from driver ground up to display supply
// Notes:   A segment counts as lit when the full supply stands across it
`timescale 1ns/1ps
module sld_glass #(
  parameter int NUM_FP = 40
) (
  input  wire logic                clk_sys,
  input  wire logic                frameStart,
  input  wire logic [3:0]          bpEn,
  input  wire logic [7:0]          bpLvl,
  input  wire logic [NUM_FP-1:0]   fpEn,
  input  wire logic [2*NUM_FP-1:0] fpLvl,
  output logic [4*NUM_FP-1:0]      litMap,
  output logic [1:0]               offGap
);
  logic [4*NUM_FP-1:0] acc;
  logic [1:0]          gap;
  ////////////////////////////////////////////////////////////////////////////////
  // Only a backplane at an outer level is selected; the others sit at a bias step
  always @(posedge clk_sys) begin
    logic [4*NUM_FP-1:0] a;
    logic [1:0]          g;
    int                  d;
    a = frameStart ? '0 : acc;
    g = frameStart ? 2'h0 : gap;
    for (int b = 0; b < 4; b++) begin
      if (bpEn[b] && (bpLvl[2*b+:2] == 2'h0 || bpLvl[2*b+:2] == 2'h3)) begin
        for (int f = 0; f < NUM_FP; f++) begin
          if (fpEn[f]) begin
            d = int'(fpLvl[2*f+:2]) - int'(bpLvl[2*b+:2]);
            if (d < 0) d = -d;
            if (d == 3) a[4*f+b] = 1'b1;
            else if (d > int'(g)) g = 2'(d);
          end
        end
      end
    end
    if (frameStart) begin
      litMap <= acc;
      offGap <= gap;
    end
    acc <= a;
    gap <= g;
  end
endmodule // sld_glass

// [tb/sld_driver_test.sv]
// Purpose: Self-checking bench for the segment display waveform driver
// Assumes: Inputs change on the falling edge; ircTick pulses every other cycle
// Notes:   DIV_BASE shrunk to 4 so the slowest prescale still runs short
`timescale 1ns/1ps
module sld_driver_test;
  import sld_pkg::*;
  localparam int NFP = 40;
  localparam int DIV = 4;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ircTick = 1'b0;
  logic displayOn = 1'b0;
  logic [NFP-1:0] frontplaneOutputEnable = '0;
  logic [2:0] lcdClockPrescale = 3'h0;
  logic dutySelectHi = 1'b0;
  logic dutySelectLo = 1'b0;
  logic biasSelect = 1'b0;
  logic haltInWait = 1'b0;
  logic waitMode = 1'b0;
  logic stopMode = 1'b0;
  logic ramWrEn = 1'b0;
  logic ramRdEn = 1'b0;
  logic [7:0] ramAddr = 8'h00;
  logic [7:0] ramWrData = 8'h00;
  logic [7:0] ramRdData;
  logic [3:0] backplaneOutputEnable;
  logic [7:0] backplaneLevel;
  logic [NFP-1:0] frontplaneDriveEnable;
  logic [2*NFP-1:0] frontplaneLevel;
  logic frameStart;
  sld_state_e driverState;
  logic [4*NFP-1:0] litMap;
  logic [1:0] offGap;
  logic [7:0] ram [20];
  logic [7:0] expQ [$];
  logic [NFP-1:0] fpEn;
  logic rdPend = 1'b0;
  integer seed = 32'h0000_9526;
  int n_fail = 0;
  int total_checks = 0;

  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) ircTick <= ~ircTick;

  sld_driver #(.NUM_FP(NFP), .DIV_BASE(DIV)) u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .ircTick(ircTick), .displayOn(displayOn), .frontplaneOutputEnable(frontplaneOutputEnable),
    .lcdClockPrescale(lcdClockPrescale), .dutySelectHi(dutySelectHi),
    .dutySelectLo(dutySelectLo), .biasSelect(biasSelect), .haltInWait(haltInWait),
    .waitMode(waitMode), .stopMode(stopMode), .ramWrEn(ramWrEn), .ramRdEn(ramRdEn),
    .ramAddr(ramAddr), .ramWrData(ramWrData), .ramRdData(ramRdData),
    .backplaneOutputEnable(backplaneOutputEnable), .backplaneLevel(backplaneLevel),
    .frontplaneDriveEnable(frontplaneDriveEnable), .frontplaneLevel(frontplaneLevel),
    .frameStart(frameStart), .driverState(driverState));

  sld_glass #(.NUM_FP(NFP)) u_glass (.clk_sys(clk_sys), .frameStart(frameStart),
    .bpEn(backplaneOutputEnable), .bpLvl(backplaneLevel), .fpEn(frontplaneDriveEnable),
    .fpLvl(frontplaneLevel), .litMap(litMap), .offGap(offGap));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [159:0] got, input logic [159:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Read data lands one edge after the strobe
  always @(posedge clk_sys) rdPend <= ramRdEn;
  always @(negedge clk_sys) begin
    if (rdPend) begin
      if (expQ.size() == 0) check(1, 0);
      else check(ramRdData, expQ.pop_front());
    end
  end

  task automatic readAll();
    for (int i = 0; i < 22; i++) begin
      ramRdEn = 1'b1;
      ramAddr = (i < 20) ? 8'(8 + i) : ((i == 20) ? 8'h07 : 8'h1C);
      expQ.push_back((i < 20) ? ram[i] : 8'h00);
      @(negedge clk_sys);
    end
    ramRdEn = 1'b0;
    repeat (3) @(negedge clk_sys);
    check(expQ.size(), 0);
  endtask

  task automatic waitFrame(output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (frameStart !== 1'b1 && n < 20000);
  endtask

  function automatic logic [159:0] expLit(input int nb);
    logic [159:0] e;
    e = '0;
    for (int f = 0; f < NFP; f++)
      e[4*f+:4] = fpEn[f] ? ram[f/2][4*(f%2)+:4] & 4'((1 << nb) - 1) : 4'h0;
    return e;
  endfunction

  // Mode p: duty code p[1:0], bias p[2], prescale p; three frames settle the change, the fourth is checked
  task automatic runMode(input int p);
    int nb;
    int n;
    nb = (p % 4 == 0) ? 4 : p % 4;
    {dutySelectHi, dutySelectLo} = 2'(p);
    biasSelect = p[2];
    lcdClockPrescale = 3'(p);
    repeat (4) waitFrame(n);
    check(n, 2 * nb * (DIV << p));
    check(backplaneOutputEnable, (1 << nb) - 1);
    check(litMap, expLit(nb));
    check(offGap, (nb == 1 || (nb == 2 && !biasSelect)) ? 0 : 1);
  endtask

  task automatic haltChk();
    int n;
    n = 0;
    check(driverState, SLD_ST_HALT);
    check({backplaneOutputEnable, frontplaneDriveEnable}, {4'hF, fpEn});
    repeat (100) begin
      @(negedge clk_sys);
      if (frameStart === 1'b1) n++;
    end
    check(n, 0);
    check({backplaneLevel, frontplaneLevel}, 0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_b = 1'b1;
    check({backplaneOutputEnable, backplaneLevel, frontplaneDriveEnable,
           frontplaneLevel, frameStart}, 0);
    check(driverState, SLD_ST_OFF);
    $display("test reset done");
    for (int i = 0; i < 20; i++) begin
      ram[i] = 8'($random(seed));
      ramWrEn = 1'b1;
      ramAddr = 8'(8 + i);
      ramWrData = ram[i];
      @(negedge clk_sys);
    end
    ramWrEn = 1'b0;
    readAll();
    $display("test memory done");
    fpEn = 40'({$random(seed), $random(seed)});
    fpEn[39] = 1'b0;
    frontplaneOutputEnable = fpEn;
    repeat (4) @(negedge clk_sys);
    check(frontplaneDriveEnable, 0);
    displayOn = 1'b1;
    @(negedge clk_sys);
    check(frontplaneDriveEnable, 0);
    @(negedge clk_sys);
    check(frontplaneDriveEnable, fpEn);
    fpEn[39] = 1'b1;
    frontplaneOutputEnable = fpEn;
    repeat (2) @(negedge clk_sys);
    check(frontplaneDriveEnable, fpEn);
    $display("test enable order done");
    for (int p = 0; p < 8; p++) runMode(p);
    $display("test modes done");
    runMode(0);
    waitMode = 1'b1;
    repeat (2) @(negedge clk_sys);
    check(driverState, SLD_ST_RUN);
    haltInWait = 1'b1;
    repeat (2) @(negedge clk_sys);
    haltChk();
    waitMode = 1'b0;
    haltInWait = 1'b0;
    stopMode = 1'b1;
    repeat (2) @(negedge clk_sys);
    haltChk();
    stopMode = 1'b0;
    repeat (2) @(negedge clk_sys);
    check(driverState, SLD_ST_RUN);
    runMode(0);
    $display("test low power done");
    displayOn = 1'b0;
    repeat (2) @(negedge clk_sys);
    check({backplaneOutputEnable, frontplaneDriveEnable}, 0);
    readAll();
    $display("test retention done");
    print_verdict();
  end

  initial begin
    #1_000_000;
    n_fail++;
    print_verdict();
  end
endmodule // sld_driver_test
